/* lvser_top.sv */
// lvds serializer and deserializer port block with axi4-lite control
// Functional notes
// R01: rx channel n occupies bits 8n-1..8n-8
// R02: tx parallel input is factor times channels
// R03: one tx serial line per channel
// R04: rx parallel output is factor times channels
// R05: one rx serial line per channel
// R06: integrator drives input clock when multi-clock on
// R07: multi-clock off, input registers on by default
// R08: rx output registered by default, parameter disables
// R09: deskew input high enters calibration mode
// R10: each side reports its pll lock
// R11: rx and tx reference clocks are output
// R12: one instance serves all channels, one pll; the code uses two trackers, one for tx and one for rx
// R13: factor may only be 4, 7 or 8
// R14: far end sends pattern at least three periods
// R15: pattern 0011, 0000111 or 00001111 per factor
// R16: normal 8x word starts at third bit
// R17: tx slices use the rx channel grouping
module lvser_top #(
  parameter int CHANNEL_COUNT = 16,   // lanes per side
  parameter int DESER_FACTOR = 8,     // bits per lane per period
  parameter bit REG_INPUT = 1'b1,     // register tx parallel input
  parameter bit MULTI_CLOCK = 1'b0,   // tx input registers on sync clock
  parameter bit REG_OUTPUT = 1'b1     // register rx parallel output
) (
  input wire logic clk,                                       // system clock
  input wire logic resetn,                                    // async reset, active low
  input wire logic [lvser_pkg::ADDR_W-1:0] s_axi_awaddr,      // write address
  input wire logic s_axi_awvalid,                             // write address valid
  output logic s_axi_awready,                                 // write address ready
  input wire logic [31:0] s_axi_wdata,                        // write data
  input wire logic [3:0] s_axi_wstrb,                         // write byte lanes
  input wire logic s_axi_wvalid,                              // write data valid
  output logic s_axi_wready,                                  // write data ready
  output logic [1:0] s_axi_bresp,                             // write response
  output logic s_axi_bvalid,                                  // write response valid
  input wire logic s_axi_bready,                              // write response ready
  input wire logic [lvser_pkg::ADDR_W-1:0] s_axi_araddr,      // read address
  input wire logic s_axi_arvalid,                             // read address valid
  output logic s_axi_arready,                                 // read address ready
  output logic [31:0] s_axi_rdata,                            // read data
  output logic [1:0] s_axi_rresp,                             // read response
  output logic s_axi_rvalid,                                  // read data valid
  input wire logic s_axi_rready,                              // read data ready
  input wire logic [DESER_FACTOR*CHANNEL_COUNT-1:0] tx_in,    // tx parallel words
  input wire logic tx_refclk,                                 // tx reference clock pin
  input wire logic sync_inclock,                              // tx input-register clock
  output logic [CHANNEL_COUNT-1:0] tx_out,                    // tx serial lines
  output logic tx_outclock,                                   // external reference clock
  output logic tx_locked,                                     // tx pll lock
  input wire logic [CHANNEL_COUNT-1:0] rx_in,                 // rx serial lines
  input wire logic rx_refclk,                                 // rx reference clock pin
  input wire logic rx_deskew,                                 // calibration request pin
  output logic [DESER_FACTOR*CHANNEL_COUNT-1:0] rx_out,       // rx parallel words
  output logic rx_out_valid,                                  // rx words updated
  output logic rx_outclock,                                   // internal reference clock
  output logic rx_locked,                                     // rx pll lock
  output logic irq                                            // level interrupt
);
  localparam int F = DESER_FACTOR;
  localparam int CH = CHANNEL_COUNT;
  localparam int W = F * CH;
  // illegal factors keep both plls out of lock, so nothing ever moves
  localparam bit FACTOR_OK = (F == 4) || (F == 7) || (F == 8);  // [R13]

  // software-visible state
  logic [1:0] ctrl;                            // calibration request, tx enable
  logic [lvser_pkg::EVT_W-1:0] int_status;     // sticky events
  logic [lvser_pkg::EVT_W-1:0] int_enable;     // interrupt mask
  logic [lvser_pkg::EVT_W-1:0] events;         // one-cycle event pulses
  logic [lvser_pkg::EVT_W-1:0] clr_mask;       // write-one-to-clear strobes
  logic wr_fire, rd_fire;                      // bus transfers taken
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // pll and framing state
  logic tx_edge, tx_bnd, rx_edge, rx_mid;
  logic tx_locked_d, rx_locked_d;              // previous lock for fall detect
  logic [CH-1:0] rx_s1, rx_s2;                 // serial line synchronisers
  logic desk_s1, desk_s2;                      // calibration pin synchroniser
  logic syn_s1, syn_s2, syn_s3;                // input-register clock sync
  logic syn_edge;
  logic cal_mode;
  logic [CH-1:0] lane_aligned;
  logic all_aligned_d;                         // previous all-aligned state
  logic [W-1:0] lane_words;                    // framed words of all lanes
  logic [W-1:0] tx_par;                        // registered tx input
  logic [W-1:0] tx_word;                       // word loaded at each edge
  logic [W-1:0] tx_shreg;                      // serializer shift registers
  logic [W-1:0] rx_hold;                       // registered rx output

  // ---------------- axi4-lite slave ----------------
  // a write is taken only when address and data are both offered
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write response, held until the master takes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lvser_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // status is read-only, so a write there is refused as well
      case (s_axi_awaddr)
        lvser_pkg::OFF_CTRL, lvser_pkg::OFF_INT_ENABLE,
        lvser_pkg::OFF_INT_CLEAR: s_axi_bresp <= lvser_pkg::RESP_OKAY;
        default: s_axi_bresp <= lvser_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control and mask registers, low byte lane only carries bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= lvser_pkg::CTRL_RESET;
      int_enable <= lvser_pkg::EVT_RESET;
    end else if (wr_fire && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == lvser_pkg::OFF_CTRL) ctrl <= s_axi_wdata[1:0];
      if (s_axi_awaddr == lvser_pkg::OFF_INT_ENABLE) begin
        int_enable <= s_axi_wdata[lvser_pkg::EVT_W-1:0];
      end
    end
  end

  // clear strobes from the write-only clear register
  assign clr_mask = (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == lvser_pkg::OFF_INT_CLEAR)
                    ? s_axi_wdata[lvser_pkg::EVT_W-1:0] : lvser_pkg::EVT_RESET;

  // read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = lvser_pkg::RESP_OKAY;
    case (s_axi_araddr)
      lvser_pkg::OFF_CTRL: next_rdata[1:0] = ctrl;
      lvser_pkg::OFF_STATUS: begin
        next_rdata[lvser_pkg::ST_TX_LOCK_BIT] = tx_locked;
        next_rdata[lvser_pkg::ST_RX_LOCK_BIT] = rx_locked;
        next_rdata[lvser_pkg::ST_CAL_BIT] = cal_mode;
        next_rdata[lvser_pkg::ST_ALIGNED_BIT] = &lane_aligned;
      end
      lvser_pkg::OFF_INT_STATUS: next_rdata[lvser_pkg::EVT_W-1:0] = int_status;
      lvser_pkg::OFF_INT_ENABLE: next_rdata[lvser_pkg::EVT_W-1:0] = int_enable;
      lvser_pkg::OFF_INT_CLEAR: next_rdata = 32'h0000_0000;  // write-only, reads zero
      default: next_rresp = lvser_pkg::RESP_SLVERR;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lvser_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- interrupts ----------------
  // lock falls are events, as is the moment all lanes frame in calibration
  assign events[lvser_pkg::EVT_TX_LOST] = tx_locked_d && !tx_locked;
  assign events[lvser_pkg::EVT_RX_LOST] = rx_locked_d && !rx_locked;
  assign events[lvser_pkg::EVT_CAL_DONE] = cal_mode && (&lane_aligned) && !all_aligned_d;

  // edge history for the event detectors
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_locked_d <= 1'b0;
      rx_locked_d <= 1'b0;
      all_aligned_d <= 1'b0;
    end else begin
      tx_locked_d <= tx_locked;
      rx_locked_d <= rx_locked;
      all_aligned_d <= &lane_aligned;
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) int_status <= lvser_pkg::EVT_RESET;
    else int_status <= (int_status & ~clr_mask) | events;
  end

  assign irq = |(int_status & int_enable);

  // ---------------- pin synchronisers ----------------
  // serial lines, deskew pin and input-register clock all arrive async
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1 <= '0;
      rx_s2 <= '0;
      desk_s1 <= 1'b0;
      desk_s2 <= 1'b0;
      syn_s1 <= 1'b0;
      syn_s2 <= 1'b0;
      syn_s3 <= 1'b0;
    end else begin
      rx_s1 <= rx_in;  // [R05]
      rx_s2 <= rx_s1;
      desk_s1 <= rx_deskew;
      desk_s2 <= desk_s1;
      syn_s1 <= sync_inclock;
      syn_s2 <= syn_s1;
      syn_s3 <= syn_s2;
    end
  end

  // a tied-low input-register clock simply never produces an edge
  assign syn_edge = syn_s2 && !syn_s3;  // [R07]
  // pin or software request puts every lane into calibration
  assign cal_mode = desk_s2 || ctrl[lvser_pkg::CTRL_CAL_BIT];  // [R09]

  // ---------------- transmitter ----------------
  // one tracker serves every lane of the transmitter
  lvser_pll #(.FACTOR(F), .ENABLE(FACTOR_OK)) u_tx_pll (  // [R12]
    .clk(clk),
    .resetn(resetn),
    .ref_pin(tx_refclk),
    .edge_pulse(tx_edge),
    .bnd_tick(tx_bnd),
    .mid_tick(),
    .locked(tx_locked),       // [R10]
    .ref_out(tx_outclock)     // [R11]
  );

  // input registers, clocked by the reference edge or the sync clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tx_par <= W'(lvser_pkg::TX_PAR_RESET);
    else if (MULTI_CLOCK ? syn_edge : tx_edge) tx_par <= tx_in;  // [R06] [R07] [R02]
  end

  // without input registering the word is taken straight from user logic
  assign tx_word = REG_INPUT ? tx_par : tx_in;  // [R07]

  // per-lane serializer, msb goes out first
  genvar gt;
  generate
    for (gt = 0; gt < CH; gt++) begin : g_tx
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          tx_shreg[gt*F +: F] <= '0;
          tx_out[gt] <= 1'b0;
        end else if (!tx_locked || !ctrl[lvser_pkg::CTRL_TX_EN_BIT]) begin
          // lines idle low while unlocked or disabled
          tx_shreg[gt*F +: F] <= '0;
          tx_out[gt] <= 1'b0;
        end else if (tx_edge) begin
          // lane gt takes the same slice the receiver gives that channel
          tx_out[gt] <= tx_word[gt*F + F - 1];  // [R17] [R03]
          tx_shreg[gt*F +: F] <= {tx_word[gt*F +: F-1], 1'b0};
        end else if (tx_bnd) begin
          tx_out[gt] <= tx_shreg[gt*F + F - 1];
          tx_shreg[gt*F +: F] <= {tx_shreg[gt*F +: F-1], 1'b0};
        end
      end
    end
  endgenerate

  // ---------------- receiver ----------------
  // one tracker serves every lane of the receiver
  lvser_pll #(.FACTOR(F), .ENABLE(FACTOR_OK)) u_rx_pll (  // [R12]
    .clk(clk),
    .resetn(resetn),
    .ref_pin(rx_refclk),
    .edge_pulse(rx_edge),
    .bnd_tick(),
    .mid_tick(rx_mid),
    .locked(rx_locked),       // [R10]
    .ref_out(rx_outclock)     // [R11]
  );

  // lanes frame independently, each with its own calibration slip
  genvar gr;
  generate
    for (gr = 0; gr < CH; gr++) begin : g_rx
      lvser_rx_lane #(.FACTOR(F)) u_lane (
        .clk(clk),
        .resetn(resetn),
        .ser_in(rx_s2[gr]),
        .edge_pulse(rx_edge),
        .mid_tick(rx_mid),
        .cal_mode(cal_mode),
        .word(lane_words[gr*F +: F]),   // [R01]
        .word_stb(),
        .aligned(lane_aligned[gr])
      );
    end
  endgenerate

  // registered output: all lanes captured together at the reference edge,
  // which costs a period of latency but keeps lanes with different slips
  // coherent in one parallel word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_hold <= '0;
      rx_out_valid <= 1'b0;
    end else begin
      rx_out_valid <= rx_edge && rx_locked;
      if (rx_edge && rx_locked) rx_hold <= lane_words;  // [R08]
    end
  end

  // unregistered mode shows the lane words as they complete
  assign rx_out = REG_OUTPUT ? rx_hold : lane_words;  // [R08] [R04]
endmodule

/* lvser_pkg.sv */
// shared constants for the lvds serializer/deserializer port block
package lvser_pkg;
  // register map, byte addresses on the axi4-lite slave
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_INT_CLEAR = 5'h10;
  // control register fields
  localparam int CTRL_CAL_BIT = 0;     // software calibration request
  localparam int CTRL_TX_EN_BIT = 1;   // transmitter drives its lines
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // live status fields
  localparam int ST_TX_LOCK_BIT = 0;
  localparam int ST_RX_LOCK_BIT = 1;
  localparam int ST_CAL_BIT = 2;
  localparam int ST_ALIGNED_BIT = 3;
  // sticky event fields
  localparam int EVT_W = 3;
  localparam int EVT_TX_LOST = 0;
  localparam int EVT_RX_LOST = 1;
  localparam int EVT_CAL_DONE = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reference clock measurement, in system clock cycles
  localparam int PERIOD_W = 8;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hff;
  localparam int LOCK_PERIODS = 4;     // matching periods before lock
  // bits of the previous word that open each normal-mode period
  localparam int NORMAL_SKIP = 2;
  // calibration patterns, first serial bit in the msb
  localparam logic [7:0] CAL_PAT4 = 8'h03;
  localparam logic [7:0] CAL_PAT7 = 8'h07;
  localparam logic [7:0] CAL_PAT8 = 8'h0f;
  localparam int TX_PAR_RESET = 0;
endpackage

/* lvser_pll.sv */
// reference clock tracker: lock detect and bit-rate tick generation
module lvser_pll #(
  parameter int FACTOR = 8,
  parameter bit ENABLE = 1'b1
) (
  input wire logic clk,          // system clock
  input wire logic resetn,       // async reset, active low
  input wire logic ref_pin,      // reference clock pin, asynchronous
  output logic edge_pulse,       // one cycle at each reference rising edge
  output logic bnd_tick,         // bit boundary inside a period
  output logic mid_tick,         // middle of each bit
  output logic locked,           // lock status
  output logic ref_out           // regenerated reference clock
);
  localparam int PW = lvser_pkg::PERIOD_W;
  logic ref_s1, ref_s2, ref_s3;  // synchroniser plus edge history
  logic [PW-1:0] cnt, last_per;  // running and last measured period
  logic [2:0] good;              // consecutive matching periods
  logic [PW+1:0] acc_b, acc_m;   // fractional bit accumulators
  logic [3:0] bidx;              // boundary count inside the period
  logic [PW-1:0] meas;
  logic match;

  // two flops before the edge detector looks at the pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      ref_s1 <= ref_pin;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  assign edge_pulse = ref_s2 & ~ref_s3;
  assign meas = cnt + 8'h01;
  // a period of one cycle tolerance still counts as matching
  assign match = (meas == last_per) || (meas == last_per + 8'h01) || (meas + 8'h01 == last_per);

  // period measurement and lock; a missing edge drops lock once the count reaches PERIOD_MAX
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      last_per <= '0;
      good <= '0;
      locked <= 1'b0;
    end else if (edge_pulse) begin
      cnt <= '0;
      last_per <= meas;
      // each bit needs two samples, so short periods never lock
      if (ENABLE && match && meas >= PW'(2 * FACTOR)) begin
        if (good == 3'(lvser_pkg::LOCK_PERIODS)) locked <= 1'b1;  // [R10]
        else good <= good + 3'h1;
      end else begin
        good <= '0;
        locked <= 1'b0;  // [R10]
      end
    end else if (cnt == lvser_pkg::PERIOD_MAX) begin
      good <= '0;
      locked <= 1'b0;  // [R10]
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // boundary ticks: factor per period, the edge itself is the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_b <= '0;
      bnd_tick <= 1'b0;
    end else if (edge_pulse) begin
      acc_b <= (PW+2)'(2 * FACTOR);
      bnd_tick <= 1'b0;
    end else if (acc_b >= {2'b00, last_per}) begin
      acc_b <= acc_b - {2'b00, last_per} + (PW+2)'(FACTOR);
      bnd_tick <= locked;
    end else begin
      acc_b <= acc_b + (PW+2)'(FACTOR);
      bnd_tick <= 1'b0;
    end
  end

  // sample ticks: one right after the edge, then one per bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_m <= '0;
      mid_tick <= 1'b0;
    end else if (edge_pulse) begin
      acc_m <= (PW+2)'(2 * FACTOR);
      mid_tick <= locked;
    end else if (acc_m >= {1'b0, last_per, 1'b0}) begin
      acc_m <= acc_m - {1'b0, last_per, 1'b0} + (PW+2)'(2 * FACTOR);
      mid_tick <= locked;
    end else begin
      acc_m <= acc_m + (PW+2)'(2 * FACTOR);
      mid_tick <= 1'b0;
    end
  end

  // regenerated clock: high over the first half of the bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bidx <= '0;
      ref_out <= 1'b0;
    end else if (edge_pulse) begin
      bidx <= '0;
      ref_out <= locked;
    end else if (bnd_tick) begin
      bidx <= bidx + 4'h1;
      ref_out <= locked && (bidx + 4'h1 < 4'(FACTOR / 2));
    end else if (!locked) begin
      ref_out <= 1'b0;
    end
  end
endmodule

/* lvser_rx_lane.sv */
// one receive channel: sampling, word framing and calibration slip
module lvser_rx_lane #(
  parameter int FACTOR = 8
) (
  input wire logic clk,               // system clock
  input wire logic resetn,            // async reset, active low
  input wire logic ser_in,            // synchronised serial line
  input wire logic edge_pulse,        // reference edge
  input wire logic mid_tick,          // bit sample point
  input wire logic cal_mode,          // calibration active
  output logic [FACTOR-1:0] word,     // last assembled word
  output logic word_stb,              // word updated
  output logic aligned                // last calibration word matched
);
  logic [2:0] bit_idx, slip;          // position in period, framing slip
  logic [FACTOR-1:0] shreg;           // newest bit at bit 0
  logic [3:0] t_sum;
  logic [2:0] target;
  logic [FACTOR-1:0] next_word;
  logic [FACTOR-1:0] pattern;
  logic hit;

  // normal framing starts two bits late, the first two close the old word
  assign t_sum = cal_mode ? {1'b0, slip} + 4'(FACTOR - 1)
                          : {1'b0, slip} + 4'(lvser_pkg::NORMAL_SKIP - 1);  // [R16]
  assign target = (t_sum >= 4'(FACTOR)) ? 3'(t_sum - 4'(FACTOR)) : t_sum[2:0];
  assign hit = mid_tick && (bit_idx == target);
  assign next_word = {shreg[FACTOR-2:0], ser_in};
  // expected calibration word for this factor
  assign pattern = (FACTOR == 4) ? FACTOR'(lvser_pkg::CAL_PAT4)
                 : (FACTOR == 7) ? FACTOR'(lvser_pkg::CAL_PAT7)
                 : FACTOR'(lvser_pkg::CAL_PAT8);  // [R15]

  // bit position restarts at every reference edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) bit_idx <= '0;
    else if (edge_pulse) bit_idx <= '0;
    else if (mid_tick) bit_idx <= (bit_idx == 3'(FACTOR - 1)) ? 3'h0 : bit_idx + 3'h1;
  end

  // shift in one bit per sample point
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) shreg <= '0;
    else if (mid_tick) shreg <= next_word;
  end

  // word hand-off, first serial bit lands in the msb
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word <= '0;
      word_stb <= 1'b0;
    end else begin
      word_stb <= hit;
      if (hit) word <= next_word;
    end
  end

  // calibration: slip one bit per mismatching word until it frames
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slip <= '0;
      aligned <= 1'b0;
    end else if (hit && cal_mode) begin
      if (next_word == pattern) begin  // [R14]
        aligned <= 1'b1;
      end else begin
        aligned <= 1'b0;
        slip <= (slip == 3'(FACTOR - 1)) ? 3'h0 : slip + 3'h1;  // [R09]
      end
    end
  end
endmodule

/* lvser_top_asserts.sv */
// checker on the pins of the lvds port block
module lvser_top_asserts #(parameter int CHANNEL_COUNT = 16, parameter int DESER_FACTOR = 8) (
  input wire logic clk, resetn, tx_locked, tx_outclock, rx_locked, rx_out_valid, // status
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready, // write
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, // read
  input wire logic [lvser_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic [CHANNEL_COUNT-1:0] tx_out, // serial lines
  input wire logic [DESER_FACTOR*CHANNEL_COUNT-1:0] rx_out // parallel words
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // awready already means both channels are valid, so it marks the taking edge
  a_wr_answer: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write answer");
  a_ro_refused: assert property (s_axi_awready && s_axi_awaddr == 5'h04 |=> s_axi_bresp == 2'h2)
    else $error("status write accepted");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_tx_quiet: assert property (!tx_locked [*2] |-> tx_out == '0)
    else $error("tx lines active while unlocked");
  a_clk_quiet: assert property (!tx_locked [*2] |-> !tx_outclock)
    else $error("tx clock active while unlocked");
  a_rx_update: assert property ($changed(rx_out) |-> rx_out_valid)
    else $error("rx words changed without valid");
  a_rx_locked: assert property (rx_out_valid |-> $past(rx_locked) && !$past(rx_out_valid))
    else $error("rx update while unlocked");
  c_rx: cover property (rx_out_valid);
  c_lock: cover property (tx_locked && rx_locked);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind lvser_top lvser_top_asserts #(.CHANNEL_COUNT(CHANNEL_COUNT), .DESER_FACTOR(DESER_FACTOR))
  u_chk (.*);

/* lvser_peer.sv */
// far-end lvds peer: free reference clock and one serial lane per channel
module lvser_peer (
  output logic refclk, // reference clock, 64 ns
  output logic [15:0] ser, // serial lanes
  input wire logic [127:0] words // lane n word at bits 8n+7..8n
);
  timeunit 1ns;
  timeprecision 100ps;
  // the reference runs free, so no idle level is needed between words
  initial begin
    refclk = 1'b0;
    forever for (int b = 7; b >= 0; b--) begin
      refclk = (b > 3); // high for the first half of each period
      for (int n = 0; n < 16; n++) ser[n] = words[8*n+b]; // msb first after the edge
      #8;
    end
  end
endmodule

/* lvser_top_test.sv */
// self-checking bench for the lvds port block
module lvser_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic tx_refclk, rx_refclk, sync_inclock, rx_deskew, s_axi_awready, s_axi_wready, irq;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_outclock, tx_locked, rx_out_valid;
  logic rx_outclock, rx_locked;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [127:0] tx_in, rx_out, words, exp_rx; // sixteen 8-bit lanes
  logic [15:0] tx_out, rx_in;
  int fail_count, checked;
  lvser_top DUT (.*);
  lvser_peer peer (.refclk(rx_refclk), .ser(rx_in), .words(words));
  assign tx_refclk = rx_refclk; // both sides share the peer reference
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin // watchdog, about six times the expected run
    #20us;
    fail_count++;
    finish_test();
  end
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // let the edge settle, wait for s, return at the edge that samples it
  task automatic waitfor(ref logic s);
    #1;
    while (s !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d, logic [1:0] resp);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    waitfor(s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    waitfor(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", resp, s_axi_bresp);
  endtask
  task automatic rd(logic [4:0] a, logic [31:0] d, logic [1:0] resp);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    waitfor(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    waitfor(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", d, s_axi_rdata);
    chk("rresp", resp, s_axi_rresp);
  endtask
  task automatic t_regs;
    rd(5'h00, 32'h2, 2'h0); // control reset value
    wr(5'h04, 32'h1, 2'h2); // status is read only
    rd(5'h14, 32'h0, 2'h2); // unmapped place
    repeat (400) if (!(tx_locked && rx_locked)) @(posedge clk);
    #1 chk("locks", 2'h3, {tx_locked, rx_locked});
    rd(5'h04, 32'h3, 2'h0);
  endtask
  // distinct word per lane; the normal-mode frame starts two bits late
  task automatic t_rx;
    logic [7:0] w;
    logic [15:0] exp_tx;
    for (int n = 0; n < 16; n++) begin
      w = 8'(n * 37 + 5);
      words[n*8+:8] <= w;
      tx_in[n*8+:8] <= ~w;
      exp_rx[n*8+:8] = {w[5:0], w[7:6]};
      exp_tx[n] = ~w[7];
    end
    repeat (200) @(posedge clk);
    #1 chk("rx_out", exp_rx, rx_out);
    @(posedge tx_outclock) #1 chk("tx_out msb", exp_tx, tx_out);
  endtask
  // pattern held 25 periods, well past the three needed
  task automatic t_cal;
    @(posedge clk);
    words <= {16{8'h0f}};
    rx_deskew <= 1'b1;
    repeat (400) @(posedge clk);
    rd(5'h04, 32'hf, 2'h0);
    rx_deskew <= 1'b0;
    rd(5'h08, 32'h4, 2'h0);
    chk("irq masked", 1'b0, irq);
    wr(5'h0c, 32'h4, 2'h0);
    #1 chk("irq", 1'b1, irq);
    wr(5'h10, 32'h4, 2'h0);
    #1 chk("irq cleared", 1'b0, irq);
    rd(5'h08, 32'h0, 2'h0);
  endtask
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sync_inclock, rx_deskew, s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_in, words} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_rx();
    t_cal();
    finish_test();
  end
endmodule
